/* src/wdrlt_top.sv */
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "wdrlt_consts.svh"

module wdrlt_top #(
  parameter logic [15:0] TICK_DIV = `WDRLT_TICK_DIV
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // power state
  input wire logic stop_mode,
  // reset requests
  output logic sys_reset_req,
  output logic stop_recovery_req,
  // interrupt
  output logic irq
);
  typedef struct packed {
    wdrlt_pkg::wdrlt_lock_e lock;
    logic [23:0] reload;
    logic [23:0] count;
    logic [2:0] ctl;
    logic [1:0] status;
    logic [1:0] mask;
    logic [7:0] rdata;
    logic [3:0] rst_cnt;
    logic stop_req;
    logic [2:0] stop_sync;
  } wdrlt_s;

  wdrlt_s q;
  wdrlt_s next_q;
  logic tick;
  logic stopped;
  logic timeout;

  // ------------------------------
  // tick source
  // ------------------------------
  wdrlt_tick #(
    .DIV(TICK_DIV)
  ) wdrlt_tick_i (
    .clock(clock),
    .rst(rst),
    .tick(tick)
  );

  function automatic logic is_reload(input logic [11:0] a);
    is_reload = (a == `WDRLT_ADDR_UPPER) || (a == `WDRLT_ADDR_MIDDLE) ||
      (a == `WDRLT_ADDR_LOWER);
  endfunction

  // stopped once synchroniser stages two and three agree
  assign stopped = (q.stop_sync[1] == q.stop_sync[2]) ? q.stop_sync[2] : q.stop_req;
  assign timeout = q.ctl[`WDRLT_CTL_ENABLE] && tick && (q.count == 24'h000001);

  // ------------------------------
  // next state
  // ------------------------------
  always_comb begin
    next_q = q;
    next_q.rdata = 8'h00;
    next_q.stop_sync = {q.stop_sync[1:0], stop_mode};
    next_q.stop_req = stopped;
    if (q.rst_cnt != 4'h0) begin
      next_q.rst_cnt = q.rst_cnt - 4'h1;
    end
    // counter
    if (q.ctl[`WDRLT_CTL_ENABLE] && tick) begin
      if (timeout) begin
        next_q.count = q.reload;
      end else begin
        next_q.count = q.count - 24'h000001;
      end
    end
    next_q.ctl[`WDRLT_CTL_REFRESH] = 1'b0;
    if (timeout) begin
      next_q.status[`WDRLT_ST_TIMEOUT] = 1'b1;
      if (stopped) begin
        next_q.status[`WDRLT_ST_STOP] = 1'b1;
      end
      if (q.ctl[`WDRLT_CTL_RESET_MODE] && !stopped) begin
        next_q.rst_cnt = `WDRLT_RESET_PULSE;
      end
    end
    // reads
    if (rd) begin
      case (addr)
        `WDRLT_ADDR_UPPER: next_q.rdata = q.count[23:16];
        `WDRLT_ADDR_MIDDLE: next_q.rdata = q.count[15:8];
        `WDRLT_ADDR_LOWER: next_q.rdata = q.count[7:0];
        `WDRLT_ADDR_STATUS: next_q.rdata = {6'h00, q.status};
        `WDRLT_ADDR_MASK: next_q.rdata = {6'h00, q.mask};
        default: next_q.rdata = 8'h00;
      endcase
    end
    // writes and lock machine
    if (wr) begin
      next_q.lock = wdrlt_pkg::WDRLT_LK_IDLE;
      case (addr)
        `WDRLT_ADDR_CTRL: begin
          if (wdata == `WDRLT_UNLOCK_FIRST) begin
            next_q.lock = wdrlt_pkg::WDRLT_LK_FIRST;
          end else if (wdata == `WDRLT_UNLOCK_SECOND &&
                       q.lock == wdrlt_pkg::WDRLT_LK_FIRST) begin
            next_q.lock = wdrlt_pkg::WDRLT_LK_UPPER;
          end else if (wdata != `WDRLT_UNLOCK_SECOND) begin
            next_q.ctl = wdata[2:0];
            if ((wdata[`WDRLT_CTL_ENABLE] && !q.ctl[`WDRLT_CTL_ENABLE]) ||
                wdata[`WDRLT_CTL_REFRESH]) begin
              next_q.count = q.reload;
            end
          end
        end
        `WDRLT_ADDR_UPPER: begin
          if (q.lock == wdrlt_pkg::WDRLT_LK_UPPER) begin
            next_q.reload[23:16] = wdata;
            next_q.lock = wdrlt_pkg::WDRLT_LK_MIDDLE;
          end
        end
        `WDRLT_ADDR_MIDDLE: begin
          if (q.lock == wdrlt_pkg::WDRLT_LK_MIDDLE) begin
            next_q.reload[15:8] = wdata;
            next_q.lock = wdrlt_pkg::WDRLT_LK_LOWER;
          end
        end
        `WDRLT_ADDR_LOWER: begin
          if (q.lock == wdrlt_pkg::WDRLT_LK_LOWER) begin
            next_q.reload[7:0] = wdata;
          end
        end
        `WDRLT_ADDR_STATUS: begin
          // write one to clear; a same-cycle event wins
          next_q.status = q.status & ~wdata[1:0];
          if (timeout) begin
            next_q.status[`WDRLT_ST_TIMEOUT] = 1'b1;
            if (stopped) begin
              next_q.status[`WDRLT_ST_STOP] = 1'b1;
            end
          end
        end
        `WDRLT_ADDR_MASK: next_q.mask = wdata[1:0];
        default: next_q.mask = q.mask;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q.lock <= wdrlt_pkg::WDRLT_LK_IDLE;
      q.reload <= `WDRLT_RESET_RELOAD;
      q.count <= `WDRLT_RESET_RELOAD;
      q.ctl <= 3'h0;
      q.status <= 2'h0;
      q.mask <= 2'h0;
      q.rdata <= 8'h00;
      q.rst_cnt <= 4'h0;
      q.stop_req <= 1'b0;
      q.stop_sync <= 3'h0;
    end else begin
      q <= next_q;
    end
  end

  // ------------------------------
  // outputs
  // ------------------------------
  assign rdata = q.rdata;
  assign sys_reset_req = (q.rst_cnt != 4'h0);
  assign stop_recovery_req = timeout && q.ctl[`WDRLT_CTL_RESET_MODE] && stopped;
  assign irq = |(q.status & q.mask);

  // ------------------------------
  // checks
  // ------------------------------
  a_unlock_no_ctl: assert property (@(posedge clock) disable iff (rst)
    wr && addr == `WDRLT_ADDR_CTRL && (wdata == `WDRLT_UNLOCK_FIRST ||
    wdata == `WDRLT_UNLOCK_SECOND) |=>
    $stable(q.ctl[`WDRLT_CTL_RESET_MODE:`WDRLT_CTL_ENABLE]) && !q.ctl[`WDRLT_CTL_REFRESH])
    else $error("unlock write changed control");
  a_locked_reload: assert property (@(posedge clock) disable iff (rst)
    wr && is_reload(addr) && q.lock == wdrlt_pkg::WDRLT_LK_IDLE |=> $stable(q.reload))
    else $error("locked reload changed");
  a_timeout_flag: assert property (@(posedge clock) disable iff (rst)
    timeout |=> q.status[`WDRLT_ST_TIMEOUT])
    else $error("timeout flag not set");
  a_stop_flags: assert property (@(posedge clock) disable iff (rst)
    timeout && stopped |=> q.status == 2'h3)
    else $error("stop flags not set");
  a_sys_reset: assert property (@(posedge clock) disable iff (rst)
    timeout && q.ctl[`WDRLT_CTL_RESET_MODE] && !stopped |=> sys_reset_req [*8])
    else $error("system reset not raised");
  a_stop_no_reset: assert property (@(posedge clock) disable iff (rst)
    stop_recovery_req && !sys_reset_req |=> !sys_reset_req)
    else $error("reset during stop recovery");
  a_other_write: assert property (@(posedge clock) disable iff (rst)
    wr && addr == `WDRLT_ADDR_MASK |=> q.lock == wdrlt_pkg::WDRLT_LK_IDLE)
    else $error("lock not reset");
  a_refresh_load: assert property (@(posedge clock) disable iff (rst)
    wr && addr == `WDRLT_ADDR_CTRL && wdata[`WDRLT_CTL_REFRESH] &&
    wdata != `WDRLT_UNLOCK_FIRST && wdata != `WDRLT_UNLOCK_SECOND |=>
    q.count == $past(q.reload))
    else $error("refresh did not load");
  a_count_read: assert property (@(posedge clock) disable iff (rst)
    rd && addr == `WDRLT_ADDR_LOWER |=> rdata == $past(q.count[7:0]))
    else $error("count read wrong");
  a_upper_read: assert property (@(posedge clock) disable iff (rst)
    rd && addr == `WDRLT_ADDR_UPPER |=> rdata == $past(q.count[23:16]))
    else $error("upper count read wrong");
  a_middle_read: assert property (@(posedge clock) disable iff (rst)
    rd && addr == `WDRLT_ADDR_MIDDLE |=> rdata == $past(q.count[15:8]))
    else $error("middle count read wrong");
  a_ctl_read: assert property (@(posedge clock) disable iff (rst)
    rd && addr == `WDRLT_ADDR_CTRL |=> rdata == 8'h00)
    else $error("control read not zero");
  a_rdata_idle: assert property (@(posedge clock) disable iff (rst)
    !rd |=> rdata == 8'h00)
    else $error("read data without read");
  a_status_read: assert property (@(posedge clock) disable iff (rst)
    rd && addr == `WDRLT_ADDR_STATUS |=> rdata == {6'h00, $past(q.status)})
    else $error("status read wrong");
  a_mask_read: assert property (@(posedge clock) disable iff (rst)
    rd && addr == `WDRLT_ADDR_MASK |=> rdata == {6'h00, $past(q.mask)})
    else $error("mask read wrong");

  // ------------------------------
  // lock machine checks
  // ------------------------------
  a_first_code: assert property (@(posedge clock) disable iff (rst)
    wr && addr == `WDRLT_ADDR_CTRL && wdata == `WDRLT_UNLOCK_FIRST |=>
    q.lock == wdrlt_pkg::WDRLT_LK_FIRST)
    else $error("first unlock code not taken");
  a_second_code: assert property (@(posedge clock) disable iff (rst)
    wr && addr == `WDRLT_ADDR_CTRL && wdata == `WDRLT_UNLOCK_SECOND &&
    q.lock == wdrlt_pkg::WDRLT_LK_FIRST |=> q.lock == wdrlt_pkg::WDRLT_LK_UPPER)
    else $error("second unlock code not taken");
  a_lone_second: assert property (@(posedge clock) disable iff (rst)
    wr && addr == `WDRLT_ADDR_CTRL && wdata == `WDRLT_UNLOCK_SECOND &&
    q.lock != wdrlt_pkg::WDRLT_LK_FIRST |=> q.lock == wdrlt_pkg::WDRLT_LK_IDLE)
    else $error("lone second code unlocked");
  a_upper_write: assert property (@(posedge clock) disable iff (rst)
    wr && addr == `WDRLT_ADDR_UPPER && q.lock == wdrlt_pkg::WDRLT_LK_UPPER |=>
    q.reload[23:16] == $past(wdata) && q.lock == wdrlt_pkg::WDRLT_LK_MIDDLE)
    else $error("upper reload byte not taken");
  a_middle_write: assert property (@(posedge clock) disable iff (rst)
    wr && addr == `WDRLT_ADDR_MIDDLE && q.lock == wdrlt_pkg::WDRLT_LK_MIDDLE |=>
    q.reload[15:8] == $past(wdata) && q.lock == wdrlt_pkg::WDRLT_LK_LOWER)
    else $error("middle reload byte not taken");
  a_lower_write: assert property (@(posedge clock) disable iff (rst)
    wr && addr == `WDRLT_ADDR_LOWER && q.lock == wdrlt_pkg::WDRLT_LK_LOWER |=>
    q.reload[7:0] == $past(wdata) && q.lock == wdrlt_pkg::WDRLT_LK_IDLE)
    else $error("low reload byte not taken");
  a_early_reload: assert property (@(posedge clock) disable iff (rst)
    wr && is_reload(addr) && q.lock == wdrlt_pkg::WDRLT_LK_FIRST |=> $stable(q.reload))
    else $error("half-unlocked reload changed");
  a_lock_hold: assert property (@(posedge clock) disable iff (rst)
    !wr |=> $stable(q.lock))
    else $error("lock moved without write");
  a_reload_hold: assert property (@(posedge clock) disable iff (rst)
    !wr |=> $stable(q.reload))
    else $error("reload moved without write");

  // ------------------------------
  // counter checks
  // ------------------------------
  a_count_step: assert property (@(posedge clock) disable iff (rst)
    q.ctl[`WDRLT_CTL_ENABLE] && tick && !timeout && !(wr && addr == `WDRLT_ADDR_CTRL) |=>
    q.count == $past(q.count) - 24'h000001)
    else $error("count did not step");
  a_count_hold: assert property (@(posedge clock) disable iff (rst)
    !q.ctl[`WDRLT_CTL_ENABLE] && !(wr && addr == `WDRLT_ADDR_CTRL) |=> $stable(q.count))
    else $error("disabled count moved");
  a_timeout_load: assert property (@(posedge clock) disable iff (rst)
    timeout && !(wr && addr == `WDRLT_ADDR_CTRL) |=> q.count == $past(q.reload))
    else $error("time-out did not reload");
  a_enable_load: assert property (@(posedge clock) disable iff (rst)
    wr && addr == `WDRLT_ADDR_CTRL && wdata[`WDRLT_CTL_ENABLE] && !q.ctl[`WDRLT_CTL_ENABLE] &&
    wdata != `WDRLT_UNLOCK_FIRST |=> q.count == $past(q.reload))
    else $error("first enable did not load");
  a_refresh_clear: assert property (@(posedge clock) disable iff (rst)
    q.ctl[`WDRLT_CTL_REFRESH] && !(wr && addr == `WDRLT_ADDR_CTRL) |=>
    !q.ctl[`WDRLT_CTL_REFRESH])
    else $error("refresh bit stuck");
  a_ctl_write: assert property (@(posedge clock) disable iff (rst)
    wr && addr == `WDRLT_ADDR_CTRL && wdata != `WDRLT_UNLOCK_FIRST &&
    wdata != `WDRLT_UNLOCK_SECOND |=> q.ctl == $past(wdata[2:0]))
    else $error("control write not taken");

  // ------------------------------
  // flag and reset checks
  // ------------------------------
  a_status_clear: assert property (@(posedge clock) disable iff (rst)
    wr && addr == `WDRLT_ADDR_STATUS && !timeout |=>
    q.status == ($past(q.status) & ~$past(wdata[1:0])))
    else $error("status write one to clear failed");
  a_flag_sticky: assert property (@(posedge clock) disable iff (rst)
    q.status[`WDRLT_ST_TIMEOUT] && !(wr && addr == `WDRLT_ADDR_STATUS) |=>
    q.status[`WDRLT_ST_TIMEOUT])
    else $error("timeout flag lost");
  a_stop_sticky: assert property (@(posedge clock) disable iff (rst)
    q.status[`WDRLT_ST_STOP] && !(wr && addr == `WDRLT_ADDR_STATUS) |=>
    q.status[`WDRLT_ST_STOP])
    else $error("stop flag lost");
  a_mask_write: assert property (@(posedge clock) disable iff (rst)
    wr && addr == `WDRLT_ADDR_MASK |=> q.mask == $past(wdata[1:0]))
    else $error("mask write not taken");
  a_reset_end: assert property (@(posedge clock) disable iff (rst)
    sys_reset_req && q.rst_cnt == 4'h1 && !timeout |=> !sys_reset_req)
    else $error("system reset too long");
  a_no_reset_mode: assert property (@(posedge clock) disable iff (rst)
    timeout && !q.ctl[`WDRLT_CTL_RESET_MODE] && !sys_reset_req |=> !sys_reset_req)
    else $error("reset without reset mode");

  // ------------------------------
  // coverage
  // ------------------------------
  c_unlock: cover property (@(posedge clock) q.lock == wdrlt_pkg::WDRLT_LK_LOWER);
  c_timeout: cover property (@(posedge clock) timeout);
  c_stop_rec: cover property (@(posedge clock) stop_recovery_req);
  c_sys_reset: cover property (@(posedge clock) $rose(sys_reset_req));
  c_flag_clear: cover property (@(posedge clock)
    wr && addr == `WDRLT_ADDR_STATUS && q.status != 2'h0);
endmodule
`default_nettype wire

/* src/wdrlt_consts.svh */
`ifndef WDRLT_CONSTS_SVH
`define WDRLT_CONSTS_SVH

// register addresses
`define WDRLT_ADDR_CTRL 12'hFF0
`define WDRLT_ADDR_UPPER 12'hFF1
`define WDRLT_ADDR_MIDDLE 12'hFF2
`define WDRLT_ADDR_LOWER 12'hFF3
`define WDRLT_ADDR_STATUS 12'hFF4
`define WDRLT_ADDR_MASK 12'hFF5

// unlock codes
`define WDRLT_UNLOCK_FIRST 8'h55
`define WDRLT_UNLOCK_SECOND 8'hAA

// reset values
`define WDRLT_RESET_RELOAD 24'h000400

// control bit positions
`define WDRLT_CTL_ENABLE 0
`define WDRLT_CTL_RESET_MODE 1
`define WDRLT_CTL_REFRESH 2

// status bit positions
`define WDRLT_ST_TIMEOUT 0
`define WDRLT_ST_STOP 1

// tick divider and reset pulse length
`define WDRLT_TICK_DIV 16'h0032
`define WDRLT_RESET_PULSE 4'h8

`endif

/* src/wdrlt_pkg.sv */
package wdrlt_pkg;
  typedef enum logic [2:0] {
    WDRLT_LK_IDLE = 3'b000,
    WDRLT_LK_FIRST = 3'b001,
    WDRLT_LK_UPPER = 3'b010,
    WDRLT_LK_MIDDLE = 3'b011,
    WDRLT_LK_LOWER = 3'b100
  } wdrlt_lock_e;
endpackage

/* src/wdrlt_tick.sv */
`timescale 1ns/1ns
`default_nettype none
`include "wdrlt_consts.svh"

// -----------------------------
// watchdog tick divider
// -----------------------------
module wdrlt_tick #(
  parameter logic [15:0] DIV = `WDRLT_TICK_DIV
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // tick out
  output logic tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } wdrlt_tick_s;

  wdrlt_tick_s q;
  wdrlt_tick_s next_q;

  always_comb begin
    next_q = q;
    next_q.tick = 1'b0;
    if (q.cnt >= DIV - 16'h0001) begin
      next_q.cnt = 16'h0000;
      next_q.tick = 1'b1;
    end else begin
      next_q.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tick = q.tick;
endmodule
`default_nettype wire

/* sim/wdrlt_top_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "wdrlt_consts.svh"

module wdrlt_top_test;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic stop_mode = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic sys_reset_req;
  logic stop_recovery_req;
  logic irq;
  logic [23:0] cur;
  logic [23:0] v;
  int errors = 0;
  int n_checks = 0;
  bit hit;

  wdrlt_top #(.TICK_DIV(16'h0002)) wdrlt_top_i (.clock(clock), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .stop_mode(stop_mode),
    .sys_reset_req(sys_reset_req), .stop_recovery_req(stop_recovery_req), .irq(irq));

  // ----------------------------
  // helpers
  // ----------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wreg(input logic [11:0] a, input logic [7:0] x);
    @(posedge clock);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask

  function automatic logic [7:0] byte_of(input logic [23:0] r, input int k);
    return r[23 - 8 * k -: 8];
  endfunction

  task automatic prog(input logic [23:0] r, input bit brk);
    wreg(`WDRLT_ADDR_CTRL, `WDRLT_UNLOCK_FIRST);
    wreg(`WDRLT_ADDR_CTRL, `WDRLT_UNLOCK_SECOND);
    // unmapped write breaks the sequence
    if (brk) wreg({4'h8, 8'($urandom)}, 8'($urandom));
    for (int k = 0; k < 3; k++) wreg(`WDRLT_ADDR_UPPER + 12'(k), byte_of(r, k));
  endtask

  task automatic wait_out(input bit stp, output bit seen);
    seen = 1'b0;
    for (int i = 0; i < 300 && !seen; i++) begin
      @(posedge clock);
      #1 seen = stp ? stop_recovery_req === 1'b1 : sys_reset_req === 1'b1;
      if (stp) chk(8'(sys_reset_req), 8'h00);
    end
  endtask

  task automatic give_verdict;
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------
  // clock, watchdog, tests
  // ----------------------------
  initial forever #10 clock = ~clock;

  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    give_verdict;
  end

  initial begin
    void'($urandom(32'h860f));
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    cur = `WDRLT_RESET_RELOAD;
    for (int k = 0; k < 3; k++) rchk(`WDRLT_ADDR_UPPER + 12'(k), byte_of(cur, k));
    rchk(`WDRLT_ADDR_CTRL, 8'h00);
    // the first unlock code carries the enable bit; counter must stay frozen
    wreg(`WDRLT_ADDR_CTRL, `WDRLT_UNLOCK_FIRST);
    wreg(`WDRLT_ADDR_CTRL, `WDRLT_UNLOCK_SECOND);
    repeat (10) @(posedge clock);
    rchk(`WDRLT_ADDR_LOWER, byte_of(cur, 2));
    wreg(12'h800, 8'h00);
    for (int t = 0; t < 9; t++) begin
      v = {8'($urandom), 8'($urandom), 8'hF0};
      if (t % 3 == 2) begin
        for (int k = 0; k < 3; k++) wreg(`WDRLT_ADDR_UPPER + 12'(k), byte_of(v, k));
      end else begin
        prog(v, t % 3 == 1);
      end
      if (t % 3 == 0) cur = v;
      wreg(`WDRLT_ADDR_CTRL, 8'h05);
      rchk(`WDRLT_ADDR_UPPER, byte_of(cur, 0));
      rchk(`WDRLT_ADDR_MIDDLE, byte_of(cur, 1));
      wreg(`WDRLT_ADDR_CTRL, 8'h00);
    end
    prog(24'h000010, 1'b0);
    wreg(`WDRLT_ADDR_STATUS, 8'h03);
    wreg(`WDRLT_ADDR_MASK, 8'h01);
    wreg(`WDRLT_ADDR_CTRL, 8'h03);
    wait_out(1'b0, hit);
    chk(8'(hit), 8'h01);
    rchk(`WDRLT_ADDR_STATUS, 8'h01);
    chk(8'(irq), 8'h01);
    wreg(`WDRLT_ADDR_MASK, 8'h00);
    #1 chk(8'(irq), 8'h00);
    wreg(`WDRLT_ADDR_CTRL, 8'h00);
    wreg(`WDRLT_ADDR_STATUS, 8'h03);
    wreg(`WDRLT_ADDR_MASK, 8'h03);
    #1 chk(8'(irq), 8'h00);
    @(posedge clock);
    stop_mode <= 1'b1;
    repeat (5) @(posedge clock);
    wreg(`WDRLT_ADDR_CTRL, 8'h03);
    wait_out(1'b1, hit);
    chk(8'(hit), 8'h01);
    rchk(`WDRLT_ADDR_STATUS, 8'h03);
    chk(8'(irq), 8'h01);
    give_verdict;
  end
endmodule

`default_nettype wire
